// ### rcfi_defines.svh
// Register offsets, field positions, reset values and timing constants.
`ifndef RCFI_DEFINES_SVH
`define RCFI_DEFINES_SVH

`define RCFI_NUM_REG 7
`define RCFI_NUM_BUCK 3
`define RCFI_NUM_LDO 4

// Register byte offsets.
`define RCFI_OFF_ON 12'h000
`define RCFI_OFF_FLT_EN 12'h004
`define RCFI_OFF_STATUS 12'h008
`define RCFI_OFF_CLEAR 12'h00C
`define RCFI_OFF_ENABLED 12'h010
`define RCFI_OFF_OK 12'h014
`define RCFI_OFF_PEND 12'h018
`define RCFI_OFF_SEL 12'h01C
`define RCFI_OFF_DIS 12'h020
`define RCFI_OFF_LOW_QUIESCENT_ENABLE 12'h024
`define RCFI_OFF_MODE 12'h028
`define RCFI_OFF_VCODE 12'h040
`define RCFI_OFF_VCODE_B1 12'h060
`define RCFI_OFF_DELAY 12'h080
`define RCFI_OFF_VOLT 12'h0A0
`define RCFI_OFF_BANK_MASK 12'hFE3
`define RCFI_IDX_LSB 2
`define RCFI_IDX_MSB 4

// Per-regulator reset values.
`define RCFI_VCODE_RESET 6'h00
`define RCFI_DELAY_RESET 3'h0

// Power-good thresholds in percent below the programmed voltage.
`define RCFI_BUCK_OK_PCT 7
`define RCFI_LDO_OK_PCT 11

// Clock and turn-on delay unit: 2 ms steps at 10 MHz.
`define RCFI_CLK_MHZ 10
`define RCFI_DELAY_UNIT_MS 2
`define RCFI_DELAY_UNIT_CYC (`RCFI_DELAY_UNIT_MS * 1000 * `RCFI_CLK_MHZ)
`define RCFI_CNT_W 21

`endif

// ### rcfi_pkg.sv
// Types shared by the regulator control block.
package rcfi_pkg;
  typedef enum logic [1:0] {
    rcfi_off,
    rcfi_wait,
    rcfi_on
  } rcfi_state_type;
endpackage

// ### rcfi_turn_on.sv
// One regulator: edge-driven enable with programmable turn-on delay.
`timescale 1ns/1ns
`include "rcfi_defines.svh"

module rcfi_turn_on (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic on_bit,
  input wire logic [2:0] delay_code,
  output logic enable
);

  rcfi_pkg::rcfi_state_type state;
  rcfi_pkg::rcfi_state_type next_state;
  logic on_prev;
  logic next_on_prev;
  logic [`RCFI_CNT_W-1:0] count;
  logic [`RCFI_CNT_W-1:0] next_count;
  logic [`RCFI_CNT_W-1:0] delay_cycles;

  // Code 0 is no delay; code n gives 2^(n-1) units of 2 ms.
  always_comb begin
    if (delay_code == 3'h0) begin
      delay_cycles = '0;
    end else begin
      delay_cycles = `RCFI_CNT_W'(`RCFI_DELAY_UNIT_CYC)
        << (delay_code - 3'h1);
    end
  end

  always_comb begin
    next_on_prev = on_bit;
    next_state = state;
    next_count = count;
    case (state)
      rcfi_pkg::rcfi_off: begin
        if (on_bit && !on_prev) begin
          next_count = '0;
          next_state = (delay_cycles == '0) ?
            rcfi_pkg::rcfi_on : rcfi_pkg::rcfi_wait;
        end
      end
      rcfi_pkg::rcfi_wait: begin
        if (!on_bit && on_prev) begin
          next_state = rcfi_pkg::rcfi_off;
        end else if (count + `RCFI_CNT_W'(1) >= delay_cycles) begin
          next_state = rcfi_pkg::rcfi_on;
        end else begin
          next_count = count + `RCFI_CNT_W'(1);
        end
      end
      rcfi_pkg::rcfi_on: begin
        if (!on_bit && on_prev) begin
          next_state = rcfi_pkg::rcfi_off;
        end
      end
      default: begin
        next_state = rcfi_pkg::rcfi_off;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rcfi_pkg::rcfi_off;
      on_prev <= 1'b0;
      count <= '0;
    end else begin
      state <= next_state;
      on_prev <= next_on_prev;
      count <= next_count;
    end
  end

  assign enable = (state == rcfi_pkg::rcfi_on);

endmodule

// ### rcfi_top.sv
// Control, status and fault interrupt logic for seven regulators.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "rcfi_defines.svh"

// What this block does
// - Buck power-good low below 7% under target.
// - LDO power-good low below 11% under target.
// - Enabled fault drives active-low interrupt.
// - Interrupt holds until recovery and flag read.
// - Decode 6-bit voltage code to millivolts.
// - LDOs reset to default code; host reprograms.
// - On-bit acts only on its edges.
// - LDO waits its turn-on delay.
// - Discharge only when disabled and bit set.
// - Low-quiescent bit sets reduced-current setting.
// - Delay codes map 0 to 128 ms.
// - Bank select picks buck voltage code.
// - Mode bit forces fixed-frequency operation.

module rcfi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic voltage_bank_select,
  input wire logic [`RCFI_NUM_REG-1:0] out_below_ok,
  output logic [`RCFI_NUM_REG-1:0] regulator_enable,
  output logic [`RCFI_NUM_REG-1:0] discharge_on,
  output logic [`RCFI_NUM_LDO-1:0] low_quiescent_on,
  output logic [`RCFI_NUM_BUCK-1:0] forced_pwm_on,
  output logic [11:0] target_mv [`RCFI_NUM_REG],
  output logic [11:0] ok_threshold_mv [`RCFI_NUM_REG],
  output logic irq_out_n
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [`RCFI_NUM_REG-1:0] on_bits, next_on_bits;
  logic [`RCFI_NUM_REG-1:0] fault_irq_enable, next_fault_irq_enable;
  logic [`RCFI_NUM_REG-1:0] discharge_enable, next_discharge_enable;
  logic [`RCFI_NUM_LDO-1:0] low_quiescent_enable, next_low_quiescent_enable;
  logic [`RCFI_NUM_BUCK-1:0] mode, next_mode;
  logic [`RCFI_NUM_REG-1:0] pend, next_pend;
  logic [`RCFI_NUM_REG-1:0] ok_read, next_ok_read;
  logic [`RCFI_NUM_REG-1:0] status, next_status;
  logic [5:0] voltage_code_bank0 [`RCFI_NUM_REG];
  logic [5:0] next_voltage_code_bank0 [`RCFI_NUM_REG];
  logic [5:0] voltage_code_bank1 [`RCFI_NUM_REG];
  logic [5:0] next_voltage_code_bank1 [`RCFI_NUM_REG];
  logic [2:0] delay_code [`RCFI_NUM_REG];
  logic [2:0] next_delay_code [`RCFI_NUM_REG];
  logic [31:0] next_prdata;

  logic wr_en;
  logic rd_en;
  logic [2:0] idx;
  logic [11:0] bank;
  logic [`RCFI_NUM_REG-1:0] ok_flag;
  logic [`RCFI_NUM_REG-1:0] fault_event;
  logic [5:0] active_code [`RCFI_NUM_REG];
  logic rd_setup;
  logic rd_miss;
  logic ok_seen;
  logic [31:0] rd_word;
  logic [`RCFI_NUM_REG-1:0] status_clear;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign idx = paddr[`RCFI_IDX_MSB:`RCFI_IDX_LSB];
  assign bank = paddr & `RCFI_OFF_BANK_MASK;
  // Every access completes in its first access cycle, with no wait state.
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // Per-regulator datapath
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `RCFI_NUM_REG; g++) begin : gen_reg
      logic [11:0] base_mv;
      logic [11:0] step_mv;
      logic [6:0] pct;

      if (g < `RCFI_NUM_BUCK) begin : gen_buck
        assign active_code[g] = voltage_bank_select ?
          voltage_code_bank1[g] : voltage_code_bank0[g];
        assign pct = 7'(`RCFI_BUCK_OK_PCT);
        assign discharge_on[g] = 1'b0;
        assign forced_pwm_on[g] = mode[g];
      end else begin : gen_ldo
        assign active_code[g] = voltage_code_bank0[g];
        assign pct = 7'(`RCFI_LDO_OK_PCT);
        assign discharge_on[g] =
          discharge_enable[g] && !regulator_enable[g];
        assign low_quiescent_on[g-`RCFI_NUM_BUCK] =
          low_quiescent_enable[g-`RCFI_NUM_BUCK];
      end

      // Base and step size per upper bits, step count per lower bits.
      always_comb begin
        case (active_code[g][5:3])
          3'h0: base_mv = 12'h258;
          3'h1: base_mv = 12'h320;
          3'h2: base_mv = 12'h3E8;
          3'h3: base_mv = 12'h4B0;
          3'h4: base_mv = 12'h640;
          3'h5: base_mv = 12'h7D0;
          3'h6: base_mv = 12'h960;
          default: base_mv = 12'hC80;
        endcase
        case (active_code[g][5:3])
          3'h0, 3'h1, 3'h2: step_mv = 12'h019;
          3'h3, 3'h4, 3'h5: step_mv = 12'h032;
          default: step_mv = 12'h064;
        endcase
      end

      assign target_mv[g] = base_mv
        + 12'(step_mv * {9'h000, active_code[g][2:0]});
      assign ok_threshold_mv[g] = target_mv[g]
        - 12'((24'(target_mv[g]) * 24'(pct)) / 24'h00_0064);

      rcfi_turn_on u_turn_on (
        .pclk(pclk),
        .presetn(presetn),
        .on_bit(on_bits[g]),
        .delay_code(delay_code[g]),
        .enable(regulator_enable[g])
      );
    end
  endgenerate

  // Power-good reads 0 while the output is under its threshold.
  assign ok_flag = ~out_below_ok;
  assign fault_event = out_below_ok & regulator_enable & fault_irq_enable;

  // ----------------------------------------------------------------
  // Register writes and read data
  // ----------------------------------------------------------------
  always_comb begin
    next_on_bits = on_bits;
    next_fault_irq_enable = fault_irq_enable;
    next_discharge_enable = discharge_enable;
    next_low_quiescent_enable = low_quiescent_enable;
    next_mode = mode;
    next_voltage_code_bank0 = voltage_code_bank0;
    next_voltage_code_bank1 = voltage_code_bank1;
    next_delay_code = delay_code;
    next_prdata = prdata;
    rd_word = 32'h0000_0000;
    rd_miss = 1'b0;
    pslverr = 1'b0;

    if (wr_en) begin
      case (paddr)
        `RCFI_OFF_ON: next_on_bits = pwdata[`RCFI_NUM_REG-1:0];
        `RCFI_OFF_FLT_EN:
          next_fault_irq_enable = pwdata[`RCFI_NUM_REG-1:0];
        // Clearing is carried out by the fault latch below.
        `RCFI_OFF_CLEAR: begin
        end
        `RCFI_OFF_DIS: next_discharge_enable = pwdata[`RCFI_NUM_REG-1:0];
        `RCFI_OFF_LOW_QUIESCENT_ENABLE:
          next_low_quiescent_enable = pwdata[`RCFI_NUM_LDO-1:0];
        `RCFI_OFF_MODE: next_mode = pwdata[`RCFI_NUM_BUCK-1:0];
        default: begin
          if (bank == `RCFI_OFF_VCODE && idx < 3'(`RCFI_NUM_REG)) begin
            next_voltage_code_bank0[idx] = pwdata[5:0];
          end else if (bank == `RCFI_OFF_VCODE_B1
                       && idx < 3'(`RCFI_NUM_BUCK)) begin
            next_voltage_code_bank1[idx] = pwdata[5:0];
          end else if (bank == `RCFI_OFF_DELAY
                       && idx < 3'(`RCFI_NUM_REG)) begin
            next_delay_code[idx] = pwdata[2:0];
          end else begin
            pslverr = 1'b1;
          end
        end
      endcase
    end

    // Read data is loaded in the setup phase so that it already stands
    // in the access phase, at the edge where the master takes it.
    case (paddr)
      `RCFI_OFF_ON: rd_word[`RCFI_NUM_REG-1:0] = on_bits;
      `RCFI_OFF_FLT_EN: rd_word[`RCFI_NUM_REG-1:0] = fault_irq_enable;
      `RCFI_OFF_STATUS: rd_word[`RCFI_NUM_REG-1:0] = status;
      `RCFI_OFF_CLEAR: rd_word = 32'h0000_0000;
      `RCFI_OFF_ENABLED: rd_word[`RCFI_NUM_REG-1:0] = regulator_enable;
      `RCFI_OFF_OK: rd_word[`RCFI_NUM_REG-1:0] = ok_flag;
      `RCFI_OFF_PEND: rd_word[`RCFI_NUM_REG-1:0] = pend;
      `RCFI_OFF_SEL: rd_word[0] = voltage_bank_select;
      `RCFI_OFF_DIS: rd_word[`RCFI_NUM_REG-1:0] = discharge_enable;
      `RCFI_OFF_LOW_QUIESCENT_ENABLE: rd_word[`RCFI_NUM_LDO-1:0] = low_quiescent_enable;
      `RCFI_OFF_MODE: rd_word[`RCFI_NUM_BUCK-1:0] = mode;
      default: begin
        if (bank == `RCFI_OFF_VCODE && idx < 3'(`RCFI_NUM_REG)) begin
          rd_word[5:0] = voltage_code_bank0[idx];
        end else if (bank == `RCFI_OFF_VCODE_B1
                     && idx < 3'(`RCFI_NUM_BUCK)) begin
          rd_word[5:0] = voltage_code_bank1[idx];
        end else if (bank == `RCFI_OFF_DELAY
                     && idx < 3'(`RCFI_NUM_REG)) begin
          rd_word[2:0] = delay_code[idx];
        end else if (bank == `RCFI_OFF_VOLT
                     && idx < 3'(`RCFI_NUM_REG)) begin
          rd_word[11:0] = target_mv[idx];
        end else begin
          rd_miss = 1'b1;
        end
      end
    endcase
    if (rd_setup) begin
      next_prdata = rd_word;
    end
    if (rd_en && rd_miss) begin
      pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_bits <= '0;
      fault_irq_enable <= '0;
      discharge_enable <= '0;
      low_quiescent_enable <= '0;
      mode <= '0;
      prdata <= 32'h0000_0000;
      for (int i = 0; i < `RCFI_NUM_REG; i++) begin
        voltage_code_bank0[i] <= `RCFI_VCODE_RESET;
        voltage_code_bank1[i] <= `RCFI_VCODE_RESET;
        delay_code[i] <= `RCFI_DELAY_RESET;
      end
    end else begin
      on_bits <= next_on_bits;
      fault_irq_enable <= next_fault_irq_enable;
      discharge_enable <= next_discharge_enable;
      low_quiescent_enable <= next_low_quiescent_enable;
      mode <= next_mode;
      prdata <= next_prdata;
      voltage_code_bank0 <= next_voltage_code_bank0;
      voltage_code_bank1 <= next_voltage_code_bank1;
      delay_code <= next_delay_code;
    end
  end

  // ----------------------------------------------------------------
  // Fault latch and interrupt
  // ----------------------------------------------------------------
  assign status_clear = (wr_en && paddr == `RCFI_OFF_CLEAR) ?
    pwdata[`RCFI_NUM_REG-1:0] : {`RCFI_NUM_REG{1'b0}};
  assign ok_seen = rd_en && (paddr == `RCFI_OFF_OK);

  // A pending fault clears once its regulator is off or back in
  // regulation and the power-good flag has been read since it rose.
  // A read made while the fault still persists counts as well.
  always_comb begin
    next_pend = pend;
    next_ok_read = ok_read | {`RCFI_NUM_REG{ok_seen}};
    next_status = status & ~status_clear;
    for (int i = 0; i < `RCFI_NUM_REG; i++) begin
      if (fault_event[i]) begin
        next_pend[i] = 1'b1;
      end else if (pend[i] && ok_read[i]
                   && (!regulator_enable[i] || !out_below_ok[i])) begin
        next_pend[i] = 1'b0;
      end
      // A new fault wins over a software clear in the same cycle and
      // forgets any read of the flags made before it.
      if (fault_event[i] && !pend[i]) begin
        next_status[i] = 1'b1;
        next_ok_read[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= '0;
      ok_read <= '0;
      status <= '0;
    end else begin
      pend <= next_pend;
      ok_read <= next_ok_read;
      status <= next_status;
    end
  end

  // Interrupt is low while any enabled fault is pending.
  assign irq_out_n = ~|(pend & fault_irq_enable);

endmodule

// ### rcfi_checker.sv
// Concurrent checks on the ports of the regulator control block.
`timescale 1ns/1ns
`include "rcfi_defines.svh"

module rcfi_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RCFI_NUM_REG-1:0] out_below_ok,
  input wire logic [`RCFI_NUM_REG-1:0] regulator_enable,
  input wire logic [`RCFI_NUM_REG-1:0] discharge_on,
  input wire logic [11:0] target_mv [`RCFI_NUM_REG],
  input wire logic [11:0] ok_threshold_mv [`RCFI_NUM_REG],
  input wire logic irq_out_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // Interrupt
  // ------------------------------------------------------------
  irq_cause_a: assert property ($fell(irq_out_n) |->
    $past(|(out_below_ok & regulator_enable)) ||
    $past(psel && penable && pwrite))
    else $error("interrupt fell without an active fault");
  irq_release_a: assert property ($rose(irq_out_n) |->
    $past(psel && penable) || $past(psel && penable, 2) ||
    $past(psel && penable, 3) ||
    |($past(out_below_ok & regulator_enable, 2) &
    ~$past(out_below_ok & regulator_enable)))
    else $error("interrupt released alone");
  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  buck_discharge_a: assert property (discharge_on[2:0] == 3'h0)
    else $error("buck discharge active");
  ldo_discharge_a: assert property ((discharge_on &
    regulator_enable) == 7'h00) else $error("discharge while enabled");
  code_range_a: assert property (target_mv[0] >= 12'h258 &&
    target_mv[0] <= 12'hF3C) else $error("voltage out of range");
  buck_margin_a: assert property (100 * ok_threshold_mv[0] + 100 >
    93 * target_mv[0] && 100 * ok_threshold_mv[0] < 93 * target_mv[0] + 100)
    else $error("buck threshold wrong");
  ldo_margin_a: assert property (100 * ok_threshold_mv[3] + 100 >
    89 * target_mv[3] && 100 * ok_threshold_mv[3] < 89 * target_mv[3] + 100)
    else $error("linear threshold wrong");
  enable_drop_a: assert property (|($past(regulator_enable) &
    ~regulator_enable) |-> $past(psel && penable && pwrite) ||
    $past(psel && penable && pwrite, 2)) else $error("enable fell alone");
endmodule

bind rcfi_top rcfi_checker chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite),
  .out_below_ok(out_below_ok), .regulator_enable(regulator_enable),
  .discharge_on(discharge_on), .target_mv(target_mv),
  .ok_threshold_mv(ok_threshold_mv), .irq_out_n(irq_out_n));

// ### rcfi_host.sv
// Host processor model that reaches the registers over APB.
`timescale 1ns/1ns

module rcfi_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // Read data and the error flag are taken at the edge that ends the
  // access phase; one idle edge follows so that outputs have settled.
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule

// ### tb.sv
// Self-checking testbench for the regulator control block.
`timescale 1ns/1ns
`include "rcfi_defines.svh"

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end end

module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic voltage_bank_select, irq_out_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] out_below_ok, regulator_enable, discharge_on;
  logic [3:0] low_quiescent_on;
  logic [2:0] forced_pwm_on;
  logic [11:0] target_mv [7];
  logic [11:0] ok_threshold_mv [7];
  int failures = 0;
  int num_checks = 0;
  logic [29:0] rows [6] = '{{6'h00, 12'h258, 12'h22E},
    {6'h07, 12'h307, 12'h000}, {6'h1B, 12'h546, 12'h000},
    {6'h2F, 12'h92E, 12'h000}, {6'h31, 12'h9C4, 12'h915},
    {6'h3F, 12'hF3C, 12'hE2B}};

  rcfi_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .voltage_bank_select(voltage_bank_select), .out_below_ok(out_below_ok),
    .regulator_enable(regulator_enable), .discharge_on(discharge_on),
    .low_quiescent_on(low_quiescent_on), .forced_pwm_on(forced_pwm_on),
    .target_mv(target_mv), .ok_threshold_mv(ok_threshold_mv),
    .irq_out_n(irq_out_n));
  rcfi_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q, err);
  endtask

  task automatic close_out();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    close_out();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    voltage_bank_select = 1'b0;
    out_below_ok = 7'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("irq", 1'b1, irq_out_n)
    `CHK("enable", 7'h00, regulator_enable)
    `CHK("ldo mv", 12'h258, target_mv[3])
    for (int i = 0; i < 6; i++) begin
      wr(12'h040, {26'h0, rows[i][29:24]});
      `CHK("mv", rows[i][23:12], target_mv[0])
      if (rows[i][11:0] != 12'h000)
        `CHK("thr", rows[i][11:0], ok_threshold_mv[0])
    end
    wr(12'h060, 32'h0000_0007);
    voltage_bank_select <= 1'b1;
    @(posedge pclk);
    `CHK("bank1", 12'h307, target_mv[0])
    voltage_bank_select <= 1'b0;
    @(posedge pclk);
    `CHK("bank0", 12'hF3C, target_mv[0])
    wr(12'h04C, 32'h0000_003F);
    `CHK("ldo thr", 12'hD8F, ok_threshold_mv[3])
    wr(12'h000, 32'h0000_0008);
    repeat (2) @(posedge pclk);
    `CHK("on", 7'h08, regulator_enable)
    wr(12'h020, 32'h0000_0078);
    wr(12'h024, 32'h0000_0005);
    wr(12'h028, 32'h0000_0006);
    `CHK("dis", 7'h70, discharge_on)
    `CHK("low_quiescent_enable", 4'h5, low_quiescent_on)
    `CHK("mode", 3'h6, forced_pwm_on)
    wr(12'h000, 32'h0000_0000);
    @(posedge pclk);
    `CHK("off", 7'h00, regulator_enable)
    `CHK("dis off", 7'h78, discharge_on)
    wr(12'h090, 32'h0000_0001);
    wr(12'h000, 32'h0000_0010);
    repeat (19990) @(posedge pclk);
    `CHK("early", 1'b0, regulator_enable[4])
    repeat (10) @(posedge pclk);
    `CHK("just early", 1'b0, regulator_enable[4])
    @(posedge pclk);
    `CHK("late", 1'b1, regulator_enable[4])
    wr(12'h004, 32'h0000_0010);
    out_below_ok <= 7'h08;
    repeat (3) @(posedge pclk);
    `CHK("masked", 1'b1, irq_out_n)
    out_below_ok <= 7'h10;
    repeat (2) @(posedge pclk);
    `CHK("fault", 1'b0, irq_out_n)
    host.xfer(1'b0, 12'h008, 32'h0, q, err);
    `CHK("status", 1'b1, q[4])
    out_below_ok <= 7'h01;
    repeat (3) @(posedge pclk);
    `CHK("held", 1'b0, irq_out_n)
    host.xfer(1'b0, 12'h014, 32'h0, q, err);
    `CHK("ok buck", 1'b0, q[0])
    `CHK("ok ldo", 1'b1, q[4])
    repeat (2) @(posedge pclk);
    `CHK("released", 1'b1, irq_out_n)
    wr(12'h00C, 32'h0000_0010);
    host.xfer(1'b0, 12'h008, 32'h0, q, err);
    `CHK("cleared", 1'b0, q[4])
    out_below_ok <= 7'h10;
    repeat (2) @(posedge pclk);
    host.xfer(1'b0, 12'h014, 32'h0, q, err);
    `CHK("ok low", 1'b0, q[4])
    `CHK("refault", 1'b0, irq_out_n)
    out_below_ok <= 7'h00;
    repeat (2) @(posedge pclk);
    `CHK("recovered", 1'b1, irq_out_n)
    host.xfer(1'b0, 12'h0FC, 32'h0, q, err);
    `CHK("unmapped", 1'b1, err)
    close_out();
  end
endmodule
